// File: core/mrs_defs.vh
// constants of the modbus rtu slave port
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH
`define MRS_CLK_HZ 100000000
`define MRS_FC_READ 8'h03
`define MRS_FC_WRITE1 8'h06
`define MRS_FC_WRITEN 8'h10
`define MRS_MAX_GROUP 16'h0010
`define MRS_NREGS 32
`define MRS_REG_MEAS 5'h01
`define MRS_REG_STAT 5'h02
`define MRS_REG_PEAK 5'h06
`define MRS_REG_TEMP 5'h08
`define MRS_REG_RELAY 5'h04
`define MRS_RELAY_MASK 16'h0003
`define MRS_ALARM_BIT 4
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_CRC_POLY 16'ha001
`define MRS_CRC_INIT 16'hffff
`define MRS_BUF_LEN 64
`define MRS_SILENCE_CHARS_X2 7
`define MRS_DEF_BAUD 32'd9600
`endif

// File: core/mrs_modbus_rtu_slave.v
// modbus rtu slave port: uart, framing, crc, holding register bank
// Contract
// R1: characters are one start bit and eight data bits, no parity
// R2: always send two stop bits; accept one or two on receive
// R3: bit rate selectable from 1200 to 115200, same at both ends; code holds the rate at 1200 or more, with no upper limit
// R4: holding registers are 16 bit, signed values two's complement
// R5: function 03h reads one register or a consecutive group
// R6: function 06h writes one register, 10h writes a group
// R7: a group read or write covers at most sixteen registers
// R8: broadcast requests are executed but never answered
// R9: measurement register is read only, signed -999 to 9999
// R10: status register read only, returns one of the status codes
// R11: relay register shows relays bits 0,1 and alarm bit 4
// R12: crc-16 checked, foreign or bad frames dropped, 3.5 char gap
// R13: bad function, address or group size answered by exception
`timescale 1ns/1ps
`include "mrs_defs.vh"
module mrs_modbus_rtu_slave
(
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_ce,
	input wire [7:0] i_slave_addr,
	input wire [31:0] i_baud,
	input wire i_rx,
	output reg o_tx,
	output reg o_tx_en,
	input wire [15:0] i_twos_complement_code,
	input wire [7:0] i_meas_status,
	input wire [15:0] i_peak_value,
	input wire [15:0] i_housing_temp,
	input wire i_alarm,
	output reg [1:0] o_relay,
	output reg o_busy
);
localparam ST_IDLE = 3'd0;
localparam ST_EXEC = 3'd1;
localparam ST_BUILD = 3'd2;
localparam ST_SEND = 3'd3;
// baud divisor; rate set by host logic, held at 1200 or more, no upper limit R3
wire [31:0] bit_div = `MRS_CLK_HZ / ((i_baud < 32'd1200) ? 32'd1200 : i_baud);
wire [31:0] gap_cyc = bit_div * 11 * `MRS_SILENCE_CHARS_X2 / 2; // R12
reg rx_m;
reg rx_s;
reg [31:0] rx_cnt;
reg [3:0] rx_bit;
reg [7:0] rx_sh;
reg rx_act;
reg [31:0] gap_cnt;
reg [7:0] buf_mem [0:`MRS_BUF_LEN-1];
reg [6:0] rx_len;
reg rx_ovf;
reg [15:0] regs [0:`MRS_NREGS-1];
reg [2:0] state;
reg [6:0] tx_len;
reg [6:0] tx_idx;
reg [31:0] tx_cnt;
reg [3:0] tx_bit;
reg [10:0] tx_sh;
reg tx_act;
reg [15:0] crc;
reg [6:0] ci;
reg [3:0] cb;
reg [15:0] grp;
reg [15:0] wi;
reg [4:0] base;
wire [15:0] start_a = {buf_mem[2], buf_mem[3]};
wire [15:0] qty = {buf_mem[4], buf_mem[5]};
wire [7:0] fc = buf_mem[1];
wire bcast = (buf_mem[0] == 8'h00);
wire [16:0] end_a = {1'b0, start_a} + {1'b0, qty};
// base latched: read data overwrites the address bytes in the buffer
wire [15:0] reg_dat = regs[base + wi[4:0]];
integer k;
// status word, read only R10
wire [15:0] stat_w = {8'h00, i_meas_status};
always @(posedge i_ref_clk or negedge i_nrst)
begin
	if (!i_nrst)
	begin
		rx_m <= 1'b1;
		rx_s <= 1'b1;
	end
	else if (i_ce)
	begin
		rx_m <= i_rx;
		rx_s <= rx_m;
	end
end
// receiver: 8 data bits, no parity; stop bit count free R1 R2
always @(posedge i_ref_clk or negedge i_nrst)
begin
	if (!i_nrst)
	begin
		rx_cnt <= 32'h0;
		rx_bit <= 4'h0;
		rx_sh <= 8'h00;
		rx_act <= 1'b0;
		gap_cnt <= 32'h0;
		rx_len <= 7'h00;
		rx_ovf <= 1'b0;
		state <= ST_IDLE;
		tx_len <= 7'h00;
		tx_idx <= 7'h00;
		tx_cnt <= 32'h0;
		tx_bit <= 4'h0;
		tx_sh <= 11'h7ff;
		tx_act <= 1'b0;
		crc <= `MRS_CRC_INIT;
		ci <= 7'h00;
		cb <= 4'h0;
		grp <= 16'h0000;
		wi <= 16'h0000;
		base <= 5'h00;
		o_tx <= 1'b1;
		o_tx_en <= 1'b0;
		o_relay <= 2'b00;
		o_busy <= 1'b0;
		for (k = 0; k < `MRS_NREGS; k = k + 1)
			regs[k] <= 16'h0000;
		for (k = 0; k < `MRS_BUF_LEN; k = k + 1)
			buf_mem[k] <= 8'h00;
	end
	else if (i_ce)
	begin
		// live inputs mirrored into the read only slots R4 R9
		regs[`MRS_REG_MEAS] <= i_twos_complement_code; // R9
		regs[`MRS_REG_STAT] <= stat_w; // R10
		regs[`MRS_REG_PEAK] <= i_peak_value;
		regs[`MRS_REG_TEMP] <= i_housing_temp;
		regs[`MRS_REG_RELAY] <= {11'h000, i_alarm, 2'b00, o_relay}; // R11
		o_busy <= (state != ST_IDLE);
		if (state == ST_IDLE && !rx_act)
		begin
			if (gap_cnt < gap_cyc)
				gap_cnt <= gap_cnt + 32'h1;
		end
		if (!rx_act)
		begin
			if (!rx_s && state == ST_IDLE)
			begin
				rx_act <= 1'b1;
				rx_cnt <= {1'b0, bit_div[31:1]};
				rx_bit <= 4'h0;
				if (gap_cnt >= gap_cyc)
				begin
					rx_len <= 7'h00; // R12
					rx_ovf <= 1'b0;
				end
				gap_cnt <= 32'h0;
			end
			else if (gap_cnt == gap_cyc - 32'h1 && rx_len != 7'h00 && state == ST_IDLE)
			begin
				state <= ST_EXEC;
				crc <= `MRS_CRC_INIT;
				ci <= 7'h00;
				cb <= 4'h0;
			end
		end
		else if (rx_cnt != 32'h0)
			rx_cnt <= rx_cnt - 32'h1;
		else
		begin
			rx_cnt <= bit_div - 32'h1;
			rx_bit <= rx_bit + 4'h1;
			if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
				rx_sh <= {rx_s, rx_sh[7:1]}; // R1
			if (rx_bit == 4'h9)
			begin
				rx_act <= 1'b0;
				if (rx_len < `MRS_BUF_LEN)
				begin
					buf_mem[rx_len[5:0]] <= rx_sh;
					rx_len <= rx_len + 7'h01;
				end
				else
					rx_ovf <= 1'b1;
			end
		end
		case (state)
		ST_IDLE:
		begin
			tx_act <= 1'b0;
		end
		ST_EXEC:
		begin
			// bitwise crc over the frame, residue zero when good R12
			if (ci < rx_len)
			begin
				if (cb == 4'h8)
				begin
					cb <= 4'h0;
					ci <= ci + 7'h01;
				end
				else
				begin
					if (cb == 4'h0)
						crc <= (((crc ^ {8'h00, buf_mem[ci[5:0]]}) >> 1) ^
							(((crc[0] ^ buf_mem[ci[5:0]][0])) ? `MRS_CRC_POLY : 16'h0));
					else
						crc <= (crc >> 1) ^ (crc[0] ? `MRS_CRC_POLY : 16'h0);
					cb <= cb + 4'h1;
				end
			end
			else if (rx_ovf || rx_len < 7'd8 || crc != 16'h0000 ||
				(buf_mem[0] != i_slave_addr && !bcast))
				state <= ST_IDLE; // R12
			else
			begin
				wi <= 16'h0000;
				base <= start_a[4:0];
				tx_len <= 7'h00;
				state <= ST_BUILD;
				buf_mem[1] <= fc;
				if (fc != `MRS_FC_READ && fc != `MRS_FC_WRITE1 && fc != `MRS_FC_WRITEN)
				begin
					buf_mem[1] <= fc | 8'h80; // R13
					buf_mem[2] <= `MRS_EXC_FUNC;
					tx_len <= 7'd3;
				end
				else if (fc != `MRS_FC_WRITE1 && (qty == 16'h0 || qty > `MRS_MAX_GROUP))
				begin
					buf_mem[1] <= fc | 8'h80; // R7 R13
					buf_mem[2] <= `MRS_EXC_VALUE;
					tx_len <= 7'd3;
				end
				else if ((fc == `MRS_FC_WRITE1 && start_a >= `MRS_NREGS) ||
					(fc != `MRS_FC_WRITE1 && end_a > `MRS_NREGS))
				begin
					buf_mem[1] <= fc | 8'h80; // R13
					buf_mem[2] <= `MRS_EXC_ADDR;
					tx_len <= 7'd3;
				end
				else if (fc == `MRS_FC_READ)
				begin
					grp <= qty; // R5
					buf_mem[2] <= {qty[6:0], 1'b0};
				end
				else if (fc == `MRS_FC_WRITE1)
					grp <= 16'h0001; // R6
				else
					grp <= qty; // R6
			end
		end
		ST_BUILD:
		begin
			if (tx_len != 7'h00)
			begin
				state <= bcast ? ST_IDLE : ST_SEND; // R8
				crc <= `MRS_CRC_INIT;
				ci <= 7'h00;
				cb <= 4'h0;
				tx_idx <= 7'h00;
			end
			else if (wi < grp)
			begin
				wi <= wi + 16'h1;
				if (fc == `MRS_FC_READ)
				begin
					buf_mem[{wi[4:0], 1'b1} + 6'd2] <= reg_dat[15:8]; // R5
					buf_mem[{wi[4:0], 1'b1} + 6'd3] <= reg_dat[7:0];
				end
				else if (start_a[4:0] + wi[4:0] == `MRS_REG_RELAY)
				begin
					// only the relay bits take a write R11
					if (fc == `MRS_FC_WRITE1)
						o_relay <= buf_mem[5][1:0];
					else
						o_relay <= buf_mem[{wi[4:0], 1'b1} + 6'd7][1:0];
				end
				else if (start_a[4:0] + wi[4:0] != `MRS_REG_MEAS &&
					start_a[4:0] + wi[4:0] != `MRS_REG_STAT)
				begin
					if (fc == `MRS_FC_WRITE1)
						regs[start_a[4:0]] <= {buf_mem[4], buf_mem[5]}; // R6
					else
						regs[start_a[4:0] + wi[4:0]] <=
							{buf_mem[{wi[4:0], 1'b1} + 6'd6], buf_mem[{wi[4:0], 1'b1} + 6'd7]};
				end
			end
			else
				tx_len <= (fc == `MRS_FC_READ) ? (7'd3 + {grp[5:0], 1'b0}) : 7'd6;
		end
		ST_SEND:
		begin
			// crc appended little end first, then sent R12
			if (ci < tx_len)
			begin
				if (cb == 4'h8)
				begin
					cb <= 4'h0;
					ci <= ci + 7'h01;
				end
				else
				begin
					if (cb == 4'h0)
						crc <= (((crc ^ {8'h00, buf_mem[ci[5:0]]}) >> 1) ^
							(((crc[0] ^ buf_mem[ci[5:0]][0])) ? `MRS_CRC_POLY : 16'h0));
					else
						crc <= (crc >> 1) ^ (crc[0] ? `MRS_CRC_POLY : 16'h0);
					cb <= cb + 4'h1;
				end
			end
			else if (ci == tx_len)
			begin
				buf_mem[tx_len[5:0]] <= crc[7:0];
				buf_mem[tx_len[5:0] + 6'd1] <= crc[15:8];
				ci <= ci + 7'h01;
			end
			else if (!tx_act)
			begin
				if (tx_idx == tx_len + 7'd2)
				begin
					state <= ST_IDLE;
					o_tx_en <= 1'b0;
					gap_cnt <= 32'h0;
					// old frame dropped, else the gap would serve it again
					rx_len <= 7'h00;
				end
				else
				begin
					// start, 8 data, two stop bits R1 R2
					tx_sh <= {2'b11, buf_mem[tx_idx[5:0]], 1'b0};
					tx_idx <= tx_idx + 7'h01;
					tx_bit <= 4'h0;
					tx_cnt <= bit_div - 32'h1;
					tx_act <= 1'b1;
					o_tx_en <= 1'b1;
					o_tx <= 1'b0;
				end
			end
			else if (tx_cnt != 32'h0)
				tx_cnt <= tx_cnt - 32'h1;
			else if (tx_bit == 4'ha)
				tx_act <= 1'b0;
			else
			begin
				tx_cnt <= bit_div - 32'h1;
				tx_bit <= tx_bit + 4'h1;
				o_tx <= tx_sh[tx_bit + 4'h1];
				tx_sh <= tx_sh;
			end
		end
		default:
			state <= ST_IDLE;
		endcase
	end
end
endmodule

// File: testbench/mrs_master.sv
// modbus rtu master model on the shared serial line
`timescale 1ns/1ps
module mrs_master
#(
	parameter int BIT = 25
)
(
	input wire i_ref_clk,
	input wire i_tx,
	input wire i_tx_en,
	output logic o_rx = 1'b1
);
function automatic logic [15:0] crc(input logic [7:0] q[$]);
	logic [15:0] c;
	c = 16'hffff;
	foreach (q[i])
	begin
		c = c ^ q[i];
		repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
	end
	return c;
endfunction
task automatic put(input logic [7:0] b, input int ns);
	logic [10:0] f;
	f = {2'b11, b, 1'b0};
	for (int i = 0; i < 9 + ns; i++)
	begin
		o_rx <= f[i];
		repeat (BIT) @(posedge i_ref_clk);
	end
endtask
task automatic send(input logic [7:0] q[$], input int ns, input logic bad);
	logic [15:0] c;
	c = crc(q) ^ 16'(bad);
	q.push_back(c[7:0]);
	q.push_back(c[15:8]);
	foreach (q[i]) put(q[i], ns);
endtask
// a silence of 15 bits after a character ends the reply
task automatic recv(output logic [7:0] r[$], output logic ok);
	int w;
	logic [7:0] b;
	r = {};
	ok = 1;
	w = 0;
	while (w < 80 * BIT)
	begin
		@(posedge i_ref_clk);
		w++;
		if (i_tx_en && !i_tx)
		begin
			repeat (BIT / 2) @(posedge i_ref_clk);
			for (int i = 0; i < 10; i++)
			begin
				repeat (BIT) @(posedge i_ref_clk);
				if (i < 8) b[i] = i_tx;
				else ok = ok & i_tx & i_tx_en;
			end
			r.push_back(b);
			w = 65 * BIT;
		end
	end
endtask
endmodule

// File: testbench/mrs_checker_asserts.sv
// port assertions of the modbus rtu slave port
`timescale 1ns/1ps
module mrs_checker
(
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_ce,
	input wire [31:0] i_baud,
	input wire i_rx,
	input wire o_tx,
	input wire o_tx_en,
	input wire [1:0] o_relay,
	input wire o_busy
);
int dv;
int hi;
int lo;
int idl;
assign dv = int'(100000000 / i_baud);
always @(posedge i_ref_clk or negedge i_nrst)
	if (!i_nrst)
	begin
		hi <= 0;
		lo <= 0;
		idl <= 0;
	end
	else
	begin
		hi <= (o_tx && o_tx_en) ? hi + 1 : 0;
		lo <= (!o_tx && o_tx_en) ? lo + 1 : 0;
		idl <= i_rx ? idl + 1 : 0;
	end
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_nrst);
tx_idle_a: assert property (!o_tx_en |-> o_tx)
	else $error("line low while driver off");
start_low_a: assert property ($fell(o_tx) |-> (o_tx_en && !o_tx) [*8])
	else $error("short low bit");
stop_two_a: assert property ($fell(o_tx_en) |-> hi >= 2 * dv - 1)
	else $error("fewer than two stop bits");
bit_time_a: assert property ($rose(o_tx) && o_tx_en |-> lo % dv == 0)
	else $error("low run not whole bits");
gap_first_a: assert property ($rose(o_tx_en) |-> idl >= 38 * dv)
	else $error("reply before frame gap");
relay_busy_a: assert property ($changed(o_relay) |-> $past(o_busy))
	else $error("relay moved outside a frame");
en_busy_a: assert property (o_tx_en |-> o_busy)
	else $error("driver on while idle");
ce_hold_a: assert property (!i_ce |=> $stable({o_tx, o_tx_en, o_relay, o_busy}))
	else $error("outputs moved while frozen");
cover property ($rose(o_tx_en));
cover property ($changed(o_relay));
cover property (!i_ce);
endmodule
bind mrs_modbus_rtu_slave mrs_checker i_chk(.i_ref_clk, .i_nrst, .i_ce, .i_baud, .i_rx,
	.o_tx, .o_tx_en, .o_relay, .o_busy);

// File: testbench/mrs_modbus_rtu_slave_bench.sv
// self-checking bench of the modbus rtu slave port
`timescale 1ns/1ps
module mrs_modbus_rtu_slave_bench;
localparam int BIT = 10;
logic i_ref_clk = 0;
logic i_nrst = 0;
logic i_ce = 1;
logic i_alarm = 1;
logic [15:0] i_twos_complement_code = 16'h0000;
logic [7:0] i_meas_status = 8'h00;
logic [7:0] q[$];
wire i_rx;
wire o_tx;
wire o_tx_en;
wire o_busy;
wire [1:0] o_relay;
wire bus_line;
int n_mismatch = 0;
int checks_done = 0;
int cyc = 0;
// meas, status, request, reply length, reply without crc
logic [131:0] rows [11] = '{
	{16'hfc19, 8'h00, 48'h0a0300010002, 4'd7, 56'h0a0304fc190000},
	{16'h270f, 8'ha0, 48'h0a0300010002, 4'd7, 56'h0a0304270f00a0},
	{16'h0000, 8'h60, 48'h0a0300010002, 4'd7, 56'h0a030400000060},
	{16'hff9c, 8'hc0, 48'h0a0300010002, 4'd7, 56'h0a0304ff9c00c0},
	{16'h0001, 8'h10, 48'h0a0300010002, 4'd7, 56'h0a030400010010},
	{16'h0064, 8'h20, 48'h0a0300010002, 4'd7, 56'h0a030400640020},
	{16'h0000, 8'h00, 48'h0a0500040001, 4'd3, 56'h0a8501},
	{16'h0000, 8'h00, 48'h0a0300010011, 4'd3, 56'h0a8303},
	{16'h0000, 8'h00, 48'h0a0300200001, 4'd3, 56'h0a8302},
	{16'h0000, 8'h00, 48'h0a06000400f2, 4'd6, 56'h0a06000400f2},
	{16'h0000, 8'h00, 48'h0a0300040001, 4'd5, 56'h0a03020012}
};
assign bus_line = o_tx_en ? o_tx : 1'b1;
mrs_master #(.BIT(BIT)) i_master(.i_ref_clk(i_ref_clk), .i_tx(bus_line), .i_tx_en(o_tx_en),
	.o_rx(i_rx));
mrs_modbus_rtu_slave i_dut(.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(i_ce),
	.i_slave_addr(8'h0a), .i_baud(32'd10000000), .i_rx(i_rx), .o_tx(o_tx), .o_tx_en(o_tx_en),
	.i_twos_complement_code(i_twos_complement_code), .i_meas_status(i_meas_status),
	.i_peak_value(16'h0000), .i_housing_temp(16'h0000), .i_alarm(i_alarm),
	.o_relay(o_relay), .o_busy(o_busy));
task automatic cmp(input logic [71:0] g, input logic [71:0] e);
	checks_done++;
	if (g !== e)
	begin
		n_mismatch++;
		$display("[ERR] %0t got=%h exp=%h", $time, g, e);
	end
endtask
task automatic give_verdict;
	if (n_mismatch == 0 && checks_done > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task automatic xact(input logic [7:0] rq[$], input int ns, input logic bad,
	input logic [3:0] len, input logic [55:0] e);
	logic [7:0] r[$];
	logic ok;
	logic [55:0] g;
	g = 0;
	i_master.send(rq, ns, bad);
	i_master.recv(r, ok);
	if (len != 0) cmp(72'(i_master.crc(r)), 72'h0);
	repeat (2) if (r.size() > 0) void'(r.pop_back());
	foreach (r[i]) g = {g[47:0], r[i]};
	cmp(72'(r.size()), 72'(len));
	cmp(72'(g), 72'(e));
	cmp(72'(ok), 72'h1);
	repeat (30 * BIT) @(posedge i_ref_clk);
endtask
initial forever #5 i_ref_clk = ~i_ref_clk;
always @(posedge i_ref_clk)
begin
	cyc++;
	if (cyc == 90000)
	begin
		n_mismatch++;
		give_verdict;
	end
end
initial
begin
	repeat (2) @(posedge i_ref_clk);
	cmp(72'({o_tx, o_tx_en, o_relay, o_busy}), 72'h10);
	repeat (2) @(posedge i_ref_clk);
	i_nrst <= 1;
	i_ce <= 0;
	repeat (20) @(posedge i_ref_clk);
	i_ce <= 1;
	repeat (40 * BIT) @(posedge i_ref_clk);
	foreach (rows[i])
	begin
		q = {};
		i_twos_complement_code <= rows[i][131:116];
		i_meas_status <= rows[i][115:108];
		for (int j = 40; j >= 0; j -= 8) q.push_back(rows[i][60 + j +: 8]);
		xact(q, 2, 0, rows[i][59:56], rows[i][55:0]);
	end
	cmp(72'(o_relay), 72'h2);
	// one stop bit on receive, group write then read back
	xact({8'h0a, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78},
		1, 0, 6, 56'h0a1000100002);
	xact({8'h0a, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, 2, 0, 7, 56'h0a030412345678);
	xact({8'h00, 8'h06, 8'h00, 8'h04, 8'h00, 8'h00}, 2, 0, 0, 56'h0);
	cmp(72'(o_relay), 72'h0);
	xact({8'h0a, 8'h06, 8'h00, 8'h04, 8'h00, 8'h03}, 2, 1, 0, 56'h0);
	xact({8'h0b, 8'h06, 8'h00, 8'h04, 8'h00, 8'h03}, 2, 0, 0, 56'h0);
	cmp(72'(o_relay), 72'h0);
	give_verdict;
end
endmodule
